// ==== verilog/phy_mgmt_defines.svh ====
// Register offsets, field positions, reset values and timing counts
// for the PHY management access unit.
// Assumes inclusion by bare name from the design files and the bench top.
`ifndef PHY_MGMT_DEFINES_SVH
`define PHY_MGMT_DEFINES_SVH

// Byte addresses of the two registers
`define ACC_CTRL_OFFSET     12'h114
`define DATA_OFFSET         12'h118
// Access control field positions
`define PHY_ADDR_MSB        15
`define PHY_ADDR_LSB        11
`define REG_INDEX_MSB       10
`define REG_INDEX_LSB       6
`define WRITE_NOT_READ_BIT  1
`define BUSY_BIT            0
// Reset values
`define PHY_ADDR_RESET      5'h00
`define REG_INDEX_RESET     5'h00
`define DATA_RESET          16'h0000
// Management cycle: 32 preamble + 32 frame bits, one bit per MDC period
`define FRAME_BITS          7'h40
`define MDC_DIV             4'h5
// AXI responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ==== verilog/phy_mgmt_pkg.sv ====
// Types shared by the PHY management access unit.
// Assumes phy_mgmt_defines.svh sits on the include path.
package phy_mgmt_pkg;

	// Access engine states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_SHIFT = 3'h2,
		ST_DONE  = 3'h4
	} mgmt_state_t;

endpackage : phy_mgmt_pkg

// ==== verilog/mdio_frame_engine.sv ====
// Serial management frame engine toward the internal PHY.
// Assumes one clock; MDC is made by dividing aclk, so it is no second domain.
`timescale 1ns/1ps
`include "phy_mgmt_defines.svh"

module mdio_frame_engine (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Request and answer
	input  wire logic        start,
	input  wire logic        write_not_read,
	input  wire logic [4:0]  phy_addr,
	input  wire logic [4:0]  reg_index,
	input  wire logic [15:0] wr_data,
	output logic             done,
	output logic      [15:0] rd_data,
	// Management pins
	output logic             mdc,
	output logic             mdio_o,
	output logic             mdio_oe,
	input  wire logic        mdio_i
);

	logic [3:0]  div_q, div_d;       // MDC divider
	logic        run_q, run_d;       // Frame in flight
	logic [6:0]  bit_q, bit_d;       // Bits sent so far
	logic [63:0] sh_q, sh_d;         // Outgoing frame
	logic        wr_q, wr_d;         // Direction latched at start
	logic [15:0] rd_q, rd_d;         // Incoming data
	logic        mdc_q, mdc_d;       // MDC level
	logic        tick;               // Falling edge of MDC: shift out
	logic        rise;               // Rising edge of MDC: sample in

	assign tick = run_q && div_q == `MDC_DIV && mdc_q;
	assign rise = run_q && div_q == `MDC_DIV && !mdc_q;

	// Next state of the serialiser
	always_comb begin
		div_d  = div_q;
		run_d  = run_q;
		bit_d  = bit_q;
		sh_d   = sh_q;
		wr_d   = wr_q;
		rd_d   = rd_q;
		mdc_d  = mdc_q;
		done   = 1'b0;
		if (start && !run_q) begin
			// Preamble, start 01, opcode 01 write / 10 read, turnaround
			run_d = 1'b1;
			bit_d = 7'h00;
			div_d = 4'h0;
			mdc_d = 1'b0;
			wr_d  = write_not_read;
			sh_d  = {32'hFFFFFFFF, 2'b01, write_not_read ? 2'b01 : 2'b10,
				phy_addr, reg_index, 2'b10, wr_data};
		end else if (run_q) begin
			div_d = (div_q == `MDC_DIV) ? 4'h0 : div_q + 4'h1;
			if (div_q == `MDC_DIV)
				mdc_d = !mdc_q;
			// Sample read data on the bits after turnaround
			if (rise && !wr_q && bit_q >= 7'h30)
				rd_d = {rd_q[14:0], mdio_i};
			if (tick) begin
				sh_d  = {sh_q[62:0], 1'b1};
				bit_d = bit_q + 7'h01;
				if (bit_q + 7'h01 == `FRAME_BITS) begin
					run_d = 1'b0;
					done  = 1'b1;
				end
			end
		end
	end

	// Serialiser registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 4'h0;
			run_q <= 1'b0;
			bit_q <= 7'h00;
			sh_q  <= 64'h0;
			wr_q  <= 1'b0;
			rd_q  <= 16'h0000;
			mdc_q <= 1'b0;
		end else begin
			div_q <= div_d;
			run_q <= run_d;
			bit_q <= bit_d;
			sh_q  <= sh_d;
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			mdc_q <= mdc_d;
		end
	end

	// Release the line during turnaround and data on a read
	assign mdio_oe = run_q && (wr_q || bit_q < 7'h2E);
	assign mdio_o  = sh_q[63];
	assign mdc     = mdc_q;
	assign rd_data = rd_q;

endmodule : mdio_frame_engine

// ==== verilog/phy_mgmt_access.sv ====
// PHY management access unit: AXI4-Lite register pair driving a
// serial management frame engine toward the internal PHY.
// Assumes an AXI4-Lite master with at most one read and one write open.
//
// How it works
// [RULE1] Software programs PHY address 00001b always
// [RULE2] Register index bits 10:6 pick target
// [RULE3] Direction bit one writes, zero reads
// [RULE4] Software sets busy bit to launch
// [RULE5] Busy held during access, self-clears after
// [RULE6] Software waits busy low before writes
// [RULE7] Write data held until busy clears
// [RULE8] Read data valid only after busy clears
// [RULE9] Data register is 16 bits, upper zero
`timescale 1ns/1ps
`include "phy_mgmt_defines.svh"

module phy_mgmt_access (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// PHY management pins
	output logic             mdc,
	output logic             mdio_o,
	output logic             mdio_oe,
	input  wire logic        mdio_i
);

	// Register fields
	logic [4:0]  phy_addr_q, phy_addr_d;
	logic [4:0]  phy_reg_index_q, phy_reg_index_d;
	logic        phy_write_not_read_q, phy_write_not_read_d;
	logic        phy_access_busy_q, phy_access_busy_d;
	logic [15:0] data_q, data_d;
	// Write channel capture
	logic        aw_have_q, aw_have_d;
	logic [11:0] aw_addr_q, aw_addr_d;
	logic        w_have_q, w_have_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0]  w_strb_q, w_strb_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	// Read channel
	logic        rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;
	// Engine handshake
	phy_mgmt_pkg::mgmt_state_t state_q, state_d;
	logic        eng_start;
	logic        eng_done;
	logic [15:0] eng_rd_data;
	logic        do_write;       // Both write halves present

	// Merge a write under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [3:0]  strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction : merge

	// Take address and data in either order; one response at a time
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready  = !w_have_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign do_write      = aw_have_q && w_have_q && !bvalid_q;
	assign eng_start     = state_q == phy_mgmt_pkg::ST_SHIFT;

	// Register and bus next state
	always_comb begin
		logic [31:0] m;
		m = 32'h0;
		phy_addr_d           = phy_addr_q;
		phy_reg_index_d      = phy_reg_index_q;
		phy_write_not_read_d = phy_write_not_read_q;
		phy_access_busy_d    = phy_access_busy_q;
		data_d               = data_q;
		aw_have_d            = aw_have_q;
		aw_addr_d            = aw_addr_q;
		w_have_d             = w_have_q;
		w_data_d             = w_data_q;
		w_strb_d             = w_strb_q;
		bvalid_d             = bvalid_q;
		bresp_d              = bresp_q;
		rvalid_d             = rvalid_q;
		rdata_d              = rdata_q;
		rresp_d              = rresp_q;
		state_d              = state_q;
		// Capture write halves
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		// Commit a write; writes while busy are dropped, software must wait
		if (do_write) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = `RESP_OKAY;
			if (aw_addr_q == `ACC_CTRL_OFFSET) begin
				if (!phy_access_busy_q) begin // RULE6
					m = merge({16'h0, phy_addr_q, phy_reg_index_q, 4'h0,
						phy_write_not_read_q, 1'b0}, w_data_q, w_strb_q);
					phy_addr_d           = m[`PHY_ADDR_MSB:`PHY_ADDR_LSB]; // RULE1
					phy_reg_index_d      = m[`REG_INDEX_MSB:`REG_INDEX_LSB]; // RULE2
					phy_write_not_read_d = m[`WRITE_NOT_READ_BIT]; // RULE3
					phy_access_busy_d    = m[`BUSY_BIT]; // RULE4
				end
			end else if (aw_addr_q == `DATA_OFFSET) begin
				if (!phy_access_busy_q) begin // RULE6 RULE7
					m      = merge({16'h0, data_q}, w_data_q, w_strb_q);
					data_d = m[15:0]; // RULE9
				end
			end else begin
				bresp_d = `RESP_SLVERR;
			end
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		// Reads answer one cycle after the address
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = `RESP_OKAY;
			if (s_axi_araddr == `ACC_CTRL_OFFSET)
				rdata_d = {16'h0, phy_addr_q, phy_reg_index_q, 4'h0,
					phy_write_not_read_q, phy_access_busy_q};
			else if (s_axi_araddr == `DATA_OFFSET)
				rdata_d = {16'h0, data_q}; // RULE9
			else begin
				rdata_d = 32'h0;
				rresp_d = `RESP_SLVERR;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		// Access sequencer
		unique case (state_q)
			phy_mgmt_pkg::ST_IDLE: begin
				if (phy_access_busy_q)
					state_d = phy_mgmt_pkg::ST_SHIFT;
			end
			phy_mgmt_pkg::ST_SHIFT: begin
				if (eng_done)
					state_d = phy_mgmt_pkg::ST_DONE;
			end
			phy_mgmt_pkg::ST_DONE: begin
				// Read data lands in the same cycle busy drops
				if (!phy_write_not_read_q)
					data_d = eng_rd_data; // RULE3 RULE8
				phy_access_busy_d = 1'b0; // RULE5
				state_d           = phy_mgmt_pkg::ST_IDLE;
			end
			default: state_d = phy_mgmt_pkg::ST_IDLE;
		endcase
	end

	// Register update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phy_addr_q           <= `PHY_ADDR_RESET;
			phy_reg_index_q      <= `REG_INDEX_RESET;
			phy_write_not_read_q <= 1'b0;
			phy_access_busy_q    <= 1'b0;
			data_q               <= `DATA_RESET;
			aw_have_q            <= 1'b0;
			aw_addr_q            <= 12'h000;
			w_have_q             <= 1'b0;
			w_data_q             <= 32'h0;
			w_strb_q             <= 4'h0;
			bvalid_q             <= 1'b0;
			bresp_q              <= 2'h0;
			rvalid_q             <= 1'b0;
			rdata_q              <= 32'h0;
			rresp_q              <= 2'h0;
			state_q              <= phy_mgmt_pkg::ST_IDLE;
		end else begin
			phy_addr_q           <= phy_addr_d;
			phy_reg_index_q      <= phy_reg_index_d;
			phy_write_not_read_q <= phy_write_not_read_d;
			phy_access_busy_q    <= phy_access_busy_d;
			data_q               <= data_d;
			aw_have_q            <= aw_have_d;
			aw_addr_q            <= aw_addr_d;
			w_have_q             <= w_have_d;
			w_data_q             <= w_data_d;
			w_strb_q             <= w_strb_d;
			bvalid_q             <= bvalid_d;
			bresp_q              <= bresp_d;
			rvalid_q             <= rvalid_d;
			rdata_q              <= rdata_d;
			rresp_q              <= rresp_d;
			state_q              <= state_d;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// Serial engine; start held through the frame, ignored once running
	mdio_frame_engine i_mdio_frame_engine (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.start          (eng_start),
		.write_not_read (phy_write_not_read_q),
		.phy_addr       (phy_addr_q),
		.reg_index      (phy_reg_index_q),
		.wr_data        (data_q),
		.done           (eng_done),
		.rd_data        (eng_rd_data),
		.mdc            (mdc),
		.mdio_o         (mdio_o),
		.mdio_oe        (mdio_oe),
		.mdio_i         (mdio_i)
	);

	// Busy stays up while the engine works
	a_busy_during_shift: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
		state_q == phy_mgmt_pkg::ST_SHIFT |-> phy_access_busy_q)
		else $error("busy dropped during access");
	// Busy is low two cycles after done
	a_busy_self_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
		eng_done |=> ##1 !phy_access_busy_q)
		else $error("busy not cleared after access");
	// Data held while busy, except the read result landing
	a_data_stable: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
		phy_access_busy_q && state_q != phy_mgmt_pkg::ST_DONE |=> $stable(data_q))
		else $error("data changed during access");
	// Read result lands on completion
	a_read_result: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
		state_q == phy_mgmt_pkg::ST_DONE && !phy_write_not_read_q
		|=> data_q == $past(eng_rd_data))
		else $error("read data not captured");
	// PHY address and register index frozen during an access
	a_ctrl_frozen: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
		phy_access_busy_q |=> $stable(phy_reg_index_q) && $stable(phy_addr_q))
		else $error("control changed while busy");
	// Upper data bits read zero
	a_data_upper: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("reserved bits not zero");
	// Setting busy launches the engine next cycle
	a_launch: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
		state_q == phy_mgmt_pkg::ST_IDLE && phy_access_busy_q |=> eng_start)
		else $error("access not launched");
	// Write response follows both halves
	a_bresp_after: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
		do_write |=> s_axi_bvalid)
		else $error("no write response");

endmodule : phy_mgmt_access

// ==== testbench/phy_mgmt_partner.sv ====
// Behavioural model of the internal PHY's management port.
// Assumes mdc is a divided copy of aclk and MDIO carries a pull-up.
`timescale 1ns/1ps
module phy_mgmt_partner (
	// Clock
	input  wire logic        aclk,
	// Management pins
	input  wire logic        mdc,
	input  wire logic        mdio_o,
	input  wire logic        mdio_oe,
	output logic             mdio_i,
	// Finished frame, for the bench
	output logic             frame_valid,
	output logic [27:0]      frame_word
);
	logic        mdc_q;      // Last mdc level
	logic [6:0]  bit_n;      // Bits seen in this frame
	logic [7:0]  idle_n;     // Cycles with mdc low
	logic [63:0] sh;         // Received bits
	logic [63:0] nx;         // Received bits plus the one on the line
	logic        rd_go;      // Read answer armed
	logic        drv_oe;     // Model drives the line
	logic        drv_o;      // Level it drives
	logic [15:0] rd;         // Word being returned
	logic [15:0] mem [0:31]; // Management registers

	// Released line floats high through the pull-up
	assign mdio_i = mdio_oe ? mdio_o : (drv_oe ? drv_o : 1'b1);
	assign nx = {sh[62:0], mdio_i};

	// Known start state
	initial begin
		for (int i = 0; i < 32; i++) mem[i] = 16'hA500 ^ 16'(i);
		{mdc_q, bit_n, idle_n, rd_go, drv_oe, drv_o, frame_valid} = '0;
	end

	// Bits taken on mdc rise, answer bits launched on mdc fall
	always @(posedge aclk) begin
		mdc_q <= mdc;
		frame_valid <= 1'b0;
		idle_n <= mdc ? 8'h00 : idle_n + 8'(idle_n != 8'hFF);
		// A long low stretch marks the gap between frames; inside a frame
		// mdc stays low six cycles at most, and gaps can be as short as 17
		if (idle_n > 8'h08) begin
			bit_n <= 7'h00;
			rd_go <= 1'b0;
		end
		if (mdc && !mdc_q) begin
			sh <= nx;
			bit_n <= bit_n + 7'h01;
			// Only address 00001b answers; others leave the pull-up
			if (bit_n == 7'h2D && nx[11:10] == 2'b10 && nx[9:5] == 5'h01) begin
				rd_go <= 1'b1;
				rd <= mem[nx[4:0]];
			end
			if (bit_n == 7'h3F) begin
				frame_valid <= 1'b1;
				frame_word <= {nx[29:18], nx[15:0]};
				rd_go <= 1'b0;
				drv_oe <= 1'b0;
				if (nx[29:28] == 2'b01) mem[nx[22:18]] <= nx[15:0];
			end
		end
		// Turnaround zero, then data MSB first
		if (!mdc && mdc_q && rd_go && bit_n >= 7'h2F) begin
			drv_oe <= 1'b1;
			drv_o <= (bit_n == 7'h2F) ? 1'b0 : rd[4'(7'h3F - bit_n)];
		end
	end
endmodule : phy_mgmt_partner

// ==== testbench/phy_mgmt_access_tb_top.sv ====
// Self-checking bench for the PHY management access unit.
// Assumes the design files and phy_mgmt_partner.sv compile first.
`timescale 1ns/1ps
`include "phy_mgmt_defines.svh"
module phy_mgmt_access_tb_top;
	logic        aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        mdc, mdio_o, mdio_oe, mdio_i, frame_valid;
	logic [27:0] frame_word;
	logic [1:0]  bq[$];        // Expected write responses
	logic [65:0] rq[$];        // Expected reads: resp, mask, data
	logic [27:0] fq[$];        // Expected frames: op, address, index, data
	logic [15:0] shadow [0:31]; // What the PHY should hold
	logic [4:0]  idx_a [0:3];  // Indices used this run
	int          bad_count, checks;

	phy_mgmt_access i_phy_mgmt_access (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.mdc, .mdio_o, .mdio_oe, .mdio_i);
	phy_mgmt_partner i_phy_mgmt_partner (.aclk, .mdc, .mdio_o, .mdio_oe, .mdio_i,
		.frame_valid, .frame_word);

	// 25 MHz clock
	initial aclk = 1'b0;
	always #20 aclk = ~aclk;

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word

	task automatic cmp_frame(input logic [27:0] got, input logic [27:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_frame

	// One write; extra edge keeps bready from toggling twice in a step
	task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : bus_wr

	// One read; mask zero means the value is only wanted, not judged
	task automatic bus_rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
			input logic [1:0] r, output logic [31:0] v);
		int n;
		rq.push_back({r, m, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		v = s_axi_rdata;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : bus_rd

	// Wait, bounded, for busy to drop
	task automatic poll;
		logic [31:0] v;
		int n;
		n = 0;
		do begin
			bus_rd(`ACC_CTRL_OFFSET, 32'h0, 32'h0, `RESP_OKAY, v);
			n++;
		end while (v[0] !== 1'b0 && n < 400);
		if (n >= 400) bad_count++;
	endtask : poll

	task automatic test_done;
		if (bq.size() || rq.size() || fq.size()) bad_count++;
		if (bad_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done

	// Results judged in order of arrival; an empty queue means a stray one
	always @(posedge aclk) begin
		logic [65:0] e;
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			cmp_word(32'(s_axi_bresp), 32'(bq.size() ? bq.pop_front() : 2'h3));
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			e = rq.size() ? rq.pop_front() : '1;
			cmp_word(32'(s_axi_rresp), 32'(e[65:64]));
			cmp_word(s_axi_rdata & e[63:32], e[31:0] & e[63:32]);
		end
		if (frame_valid === 1'b1)
			cmp_frame(frame_word, fq.size() ? fq.pop_front() : '1);
	end

	// Watchdog, far beyond ten frames
	initial begin
		repeat (30000) @(posedge aclk);
		bad_count++;
		test_done();
	end

	initial begin
		logic [31:0] v, d, ctl;
		void'($urandom(6413));
		{aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		bus_rd(`ACC_CTRL_OFFSET, 32'h0, 32'hFFFF_FFFF, `RESP_OKAY, v);
		bus_rd(`DATA_OFFSET, 32'h0, 32'hFFFF_FFFF, `RESP_OKAY, v);
		// Writes, with a dropped data write while busy
		for (int k = 0; k < 4; k++) begin
			idx_a[k] = 5'($urandom);
			d = $urandom;
			ctl = {16'h0000, 5'h01, idx_a[k], 4'h0, 2'h3};
			bus_wr(`DATA_OFFSET, d, `RESP_OKAY);
			bus_rd(`DATA_OFFSET, {16'h0000, d[15:0]}, 32'hFFFF_FFFF, `RESP_OKAY, v);
			shadow[idx_a[k]] = d[15:0];
			fq.push_back({2'h1, 5'h01, idx_a[k], d[15:0]});
			bus_wr(`ACC_CTRL_OFFSET, ctl, `RESP_OKAY);
			bus_rd(`ACC_CTRL_OFFSET, ctl, 32'hFFFF_FFFF, `RESP_OKAY, v);
			bus_wr(`DATA_OFFSET, ~d, `RESP_OKAY);
			poll();
			bus_rd(`DATA_OFFSET, {16'h0000, d[15:0]}, 32'hFFFF_FFFF, `RESP_OKAY, v);
			bus_rd(`ACC_CTRL_OFFSET, ctl ^ 32'h1, 32'hFFFF_FFFF, `RESP_OKAY, v);
		end
		// Reads back; the last one aims at an absent address
		for (int k = 0; k < 5; k++) begin
			ctl = {16'h0000, 5'(k / 4 + 1), idx_a[k % 4], 4'h0, 2'h1};
			d = (k == 4) ? 32'h0000_FFFF : {16'h0000, shadow[idx_a[k % 4]]};
			fq.push_back({2'h2, ctl[15:6], d[15:0]});
			bus_wr(`ACC_CTRL_OFFSET, ctl, `RESP_OKAY);
			poll();
			bus_rd(`DATA_OFFSET, d, 32'hFFFF_FFFF, `RESP_OKAY, v);
		end
		// No busy bit, no frame
		bus_wr(`ACC_CTRL_OFFSET, 32'h0000_0842, `RESP_OKAY);
		bus_rd(`ACC_CTRL_OFFSET, 32'h0000_0842, 32'hFFFF_FFFF, `RESP_OKAY, v);
		// Unmapped places
		bus_wr(12'h11C, $urandom, `RESP_SLVERR);
		bus_rd(12'h200, 32'h0, 32'hFFFF_FFFF, `RESP_SLVERR, v);
		test_done();
	end
endmodule : phy_mgmt_access_tb_top
